// [bench/sbf_bypass_fault_checker.sv]
// Concurrent checks on the ports of the bypass and fault status block.
// Bound to the top module; watches its ports only, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module sbf_bypass_fault_checker
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic o_reg_rvalid,
  input wire logic i_config_fail,
  input wire logic i_power_transient,
  input wire logic i_watchdog_trip,
  input wire logic i_error_event,
  input wire logic i_host_scl,
  input wire logic o_host_sda_oe_n,
  input wire logic o_sen_scl_oe_n,
  input wire logic o_fusion_enable,
  input wire logic o_sensor_power,
  input wire logic o_host_irq,
  input wire logic o_bypass_active
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Any of the three hardware fault sources
  wire logic hw_fault = i_config_fail | i_power_transient | i_watchdog_trip;
  // Bypass keeps fusion, sensor power and the interrupt off
  bypass_quiet_a: assert property (
    o_bypass_active |-> !o_fusion_enable && !o_sensor_power && !o_host_irq)
    else $error("bypass left a function running");
  read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  bypass_entry_a: assert property (
    $rose(o_bypass_active) |-> $past(i_reg_wr && i_reg_addr == 8'ha0 && i_reg_wdata[0]))
    else $error("bypass entered without a write");
  standby_entry_a: assert property (
    i_reg_wr && i_reg_addr == 8'h54 && i_reg_wdata[0] && !o_bypass_active
    |=> !o_fusion_enable && !o_sensor_power)
    else $error("standby write did not stop fusion");
  fault_stop_a: assert property (
    hw_fault |=> !o_sensor_power && !o_fusion_enable && !o_bypass_active && o_host_irq)
    else $error("fault did not force standby");
  // A read clears every flag, so with no new event the interrupt drops
  flag_clear_a: assert property (
    i_reg_rd && i_reg_addr == 8'h35 && !hw_fault && !i_error_event && !i_reg_wr
    |=> !o_host_irq)
    else $error("event read did not clear");
  link_scl_a: assert property (
    $past(o_bypass_active) && o_bypass_active && !i_host_scl |=> !o_sen_scl_oe_n)
    else $error("host clock not passed to sensor bus");
  // Three idle cycles allow for the bridge seeing bypass one cycle late
  host_release_a: assert property (
    !o_bypass_active [*3] |-> o_host_sda_oe_n)
    else $error("host data driven outside bypass");
  cover property (o_bypass_active && !o_sen_scl_oe_n);
  cover property (hw_fault ##1 o_host_irq);
  cover property ($fell(o_bypass_active));
endmodule // sbf_bypass_fault_checker
bind sbf_bypass_fault_top sbf_bypass_fault_checker u_chk (.*);
`default_nettype wire

// [bench/sbf_bypass_fault_top_bench.sv]
// Self-checking bench: register strobes, event pulses, pin traffic.
// Inputs change on the falling edge; the design samples on the rising.
`timescale 1ns/10ps
`default_nettype none
module sbf_bypass_fault_top_bench;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] addr = 0;
  logic [7:0] wdata = 0;
  logic wr = 0, rd = 0, mscl = 0, msda = 0, hscl_lo = 0, hsda_lo = 0, ssda_lo = 0;
  logic [19:0] ev = 0;
  wire logic [7:0] rdata;
  wire logic rvalid, hsda_oe_n, sscl_oe_n, ssda_oe_n, fus, pwr, irq, byp;
  wire logic h_scl, h_sda, s_scl, s_sda;
  wire logic hsda_v, sscl_v, ssda_v;
  int n_mismatch = 0;
  int n_checks = 0;
  int i;
  logic [7:0] ra [12] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h50, 8'h9e,
    8'h10, 8'h54, 8'ha0, 8'h55, 8'h56, 8'h57};
  logic [7:0] re [12] = '{0, 0, 8'h08, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [7:0] codes [8] = '{8'h80, 8'h30, 8'h21, 8'h22, 8'h24, 8'h11, 8'h12, 8'h14};

  sbf_bypass_fault_top dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_config_done(ev[0]), .i_run_request(ev[1]),
    .i_config_fail(ev[2]), .i_power_transient(ev[3]), .i_watchdog_trip(ev[4]),
    .i_error_event(ev[5]), .i_bad_rate(ev[6]), .i_math_fault(ev[7]),
    .i_init_fail(ev[10:8]), .i_rate_fail(ev[13:11]), .i_no_ack(ev[16:14]),
    .i_id_mismatch(ev[19:17]), .i_host_scl(h_scl), .i_host_sda(h_sda), .o_host_sda(hsda_v),
    .o_host_sda_oe_n(hsda_oe_n), .i_sen_scl(s_scl), .i_sen_sda(s_sda), .o_sen_scl(sscl_v),
    .o_sen_scl_oe_n(sscl_oe_n), .o_sen_sda(ssda_v), .o_sen_sda_oe_n(ssda_oe_n),
    .i_mst_scl_low(mscl), .i_mst_sda_low(msda), .o_fusion_enable(fus),
    .o_sensor_power(pwr), .o_host_irq(irq), .o_bypass_active(byp));

  sbf_pin_model u_pins (.i_host_scl_low(hscl_lo), .i_host_sda_low(hsda_lo),
    .i_sen_sda_low(ssda_lo), .i_dev_host_sda_oe_n(hsda_oe_n),
    .i_dev_sen_scl_oe_n(sscl_oe_n), .i_dev_sen_sda_oe_n(ssda_oe_n),
    .o_host_scl(h_scl), .o_host_sda(h_sda), .o_sen_scl(s_scl), .o_sen_sda(s_sda));

  // 100 ns period
  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask

  // Read strobe, then a bounded wait for the answer pulse
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    int k;
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++)
      @(negedge clk);
    if (rvalid !== 1'b1)
    begin
      n_mismatch++;
      $display("Error at %0t: read of %h not answered", $time, a);
      results();
    end
    else
      chk(rdata, e);
  endtask

  task automatic pls(input logic [19:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = 0;
  endtask

  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    rdc(8'h35, 8'h01);
    rdc(8'h35, 8'h00);
    // Status places must keep their value under writes
    for (i = 0; i < 7; i++)
      wrc(ra[i], 8'hff);
    for (i = 0; i < 12; i++)
      rdc(ra[i], re[i]);
    wrc(8'h56, 8'h3c);
    rdc(8'h56, 8'h3c);
    pls(20'h1);
    rdc(8'h37, 8'h08);
    pls(20'h2);
    rdc(8'h37, 8'h00);
    chk(fus, 1);
    // Bypass request from normal operation is not honoured
    wrc(8'ha0, 8'h01);
    chk(byp, 0);
    wrc(8'h54, 8'h01);
    chk(fus, 0);
    rdc(8'h38, 8'h01);
    wrc(8'ha0, 8'h01);
    chk({byp, pwr, irq}, 8'h04);
    rdc(8'h9e, 8'h01);
    // Internal master asks for the bus; bypass must not let it through
    mscl = 1;
    hscl_lo = 1;
    repeat (2) @(negedge clk);
    chk(s_scl, 0);
    hscl_lo = 0;
    hsda_lo = 1;
    repeat (2) @(negedge clk);
    chk({s_scl, s_sda}, 8'h02);
    hsda_lo = 0;
    ssda_lo = 1;
    repeat (2) @(negedge clk);
    chk(h_sda, 0);
    ssda_lo = 0;
    mscl = 0;
    pls(20'h20);
    chk(irq, 0);
    wrc(8'ha0, 8'h00);
    chk({byp, irq}, 8'h01);
    rdc(8'h38, 8'h01);
    rdc(8'h9e, 8'h00);
    wrc(8'h54, 8'h00);
    chk(fus, 1);
    // Outside bypass the internal master owns the sensor bus; host sees nothing
    mscl = 1;
    msda = 1;
    ssda_lo = 1;
    repeat (2) @(negedge clk);
    chk({s_scl, s_sda, h_sda}, 8'h01);
    chk({hsda_v, sscl_v, ssda_v}, 8'h00);
    mscl = 0;
    msda = 0;
    ssda_lo = 0;
    rdc(8'h35, 8'h02);
    chk(irq, 0);
    // Each hardware fault from normal operation
    for (i = 2; i < 5; i++)
    begin
      wrc(8'h55, 8'h0a);
      pls(20'h1 << i);
      chk({pwr, irq}, 8'h01);
      rdc(8'h38, 8'h01);
      rdc(8'h55, 8'h00);
      rdc(8'h37, 8'h04);
      rdc(8'h35, 8'h02);
      wrc(8'h54, 8'h00);
    end
    for (i = 0; i < 8; i++)
    begin
      pls(20'h40 << i);
      rdc(8'h50, codes[i]);
    end
    pls(20'h54000);
    rdc(8'h36, 8'h25);
    // Only the exact restart command counts
    wrc(8'h9b, 8'h02);
    rdc(8'h36, 8'h25);
    wrc(8'h9b, 8'h01);
    for (i = 0; i < 6; i++)
      rdc(ra[i], i == 0 ? 8'h01 : re[i]);
    // Bypass straight from the unprogrammed state returns there on exit
    wrc(8'ha0, 8'h01);
    rdc(8'h9e, 8'h01);
    wrc(8'ha0, 8'h00);
    rdc(8'h37, 8'h08);
    // Reset in mid-run raises the restarted flag again
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    rdc(8'h35, 8'h01);
    results();
  end
endmodule // sbf_bypass_fault_top_bench
`default_nettype wire

// [bench/sbf_pin_model.sv]
// Host pins and sensor bus wires: host master, one sensor, pull-ups.
// Assumes all open-drain drivers only ever pull low.
`timescale 1ns/10ps
`default_nettype none
module sbf_pin_model
(
  input wire logic i_host_scl_low,
  input wire logic i_host_sda_low,
  input wire logic i_sen_sda_low,
  input wire logic i_dev_host_sda_oe_n,
  input wire logic i_dev_sen_scl_oe_n,
  input wire logic i_dev_sen_sda_oe_n,
  output logic o_host_scl,
  output logic o_host_sda,
  output logic o_sen_scl,
  output logic o_sen_sda
);
  // Wired-and with pull-ups, so a released line reads high, never stale
  assign o_host_scl = !i_host_scl_low;
  assign o_host_sda = !(i_host_sda_low || !i_dev_host_sda_oe_n);
  assign o_sen_scl = i_dev_sen_scl_oe_n;
  assign o_sen_sda = !(i_sen_sda_low || !i_dev_sen_sda_oe_n);
endmodule // sbf_pin_model
`default_nettype wire

// [rtl/sbf_bypass_fault_top.v]
// Operating state, bypass switching and fault status registers of the
// motion coprocessor, as seen from the host.
// Assumes a serial slave front end that presents each register access
// as a one-cycle read or write strobe with an 8-bit address.
`timescale 1ns/10ps
`default_nettype none
`include "sbf_map.vh"
module sbf_bypass_fault_top
(
  input wire i_sys_clk,
  input wire i_reset_n,
  // Decoded register access
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // Firmware and loader events
  input wire i_config_done,
  input wire i_run_request,
  input wire i_config_fail,
  input wire i_power_transient,
  input wire i_watchdog_trip,
  input wire i_error_event,
  input wire [2:0] i_no_ack,
  input wire [2:0] i_id_mismatch,
  input wire i_bad_rate,
  input wire i_math_fault,
  input wire [2:0] i_init_fail,
  input wire [2:0] i_rate_fail,
  // Host serial port pins
  input wire i_host_scl,
  input wire i_host_sda,
  output reg o_host_sda,
  output wire o_host_sda_oe_n,
  // Sensor bus pins and internal master requests
  input wire i_sen_scl,
  input wire i_sen_sda,
  output reg o_sen_scl,
  output wire o_sen_scl_oe_n,
  output reg o_sen_sda,
  output wire o_sen_sda_oe_n,
  input wire i_mst_scl_low,
  input wire i_mst_sda_low,
  // Block controls
  output reg o_fusion_enable,
  output reg o_sensor_power,
  output reg o_host_irq,
  output reg o_bypass_active
);
  localparam ST_UNPROG = 3'd0;
  localparam ST_INIT = 3'd1;
  localparam ST_NORMAL = 3'd2;
  localparam ST_STANDBY = 3'd3;
  localparam ST_BYPASS = 3'd4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] prior_r;
  reg [2:0] prior_nxt;
  reg proc_ctrl_r;
  reg proc_ctrl_nxt;
  reg byp_ctrl_r;
  reg byp_ctrl_nxt;
  reg [1:0] event_r;
  reg [1:0] event_nxt;
  reg [2:0] no_ack_r;
  reg [2:0] no_ack_nxt;
  reg [2:0] id_err_r;
  reg [2:0] id_err_nxt;
  reg load_fail_r;
  reg load_fail_nxt;
  reg [7:0] mag_rate_r;
  reg [7:0] mag_rate_nxt;
  reg [7:0] acc_rate_r;
  reg [7:0] acc_rate_nxt;
  reg [7:0] gyr_rate_r;
  reg [7:0] gyr_rate_nxt;
  reg [7:0] rdata_nxt;
  wire [7:0] fault_code;
  wire hw_fault;
  wire restart;
  wire wr_proc;
  wire wr_byp;
  wire rd_event;
  wire idle;
  wire byp_allowed;

  // Access decode; writes to status offsets simply match nothing here
  assign wr_proc = i_reg_wr && (i_reg_addr == `SBF_OFS_PROC_CTRL);
  assign wr_byp = i_reg_wr && (i_reg_addr == `SBF_OFS_BYP_CTRL);
  assign restart = i_reg_wr && (i_reg_addr == `SBF_OFS_RESTART) &&
                   (i_reg_wdata == `SBF_RESTART_CMD);
  assign rd_event = i_reg_rd && (i_reg_addr == `SBF_OFS_EVENT_FLAGS);

  // Any of these means the hardware can no longer be trusted
  assign hw_fault = i_config_fail | i_power_transient | i_watchdog_trip;

  assign idle = (state_r == ST_INIT) || (state_r == ST_UNPROG);

  // Bypass is refused from normal operation so fusion is never cut mid-run
  assign byp_allowed = (state_r == ST_STANDBY) || idle;

  // Fault code register, cleared only by a restart
  sbf_fault_enc u_fault_enc
  (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clear(restart),
    .i_bad_rate(i_bad_rate),
    .i_math_fault(i_math_fault),
    .i_init_fail(i_init_fail),
    .i_rate_fail(i_rate_fail),
    .o_code(fault_code)
  );

  // Pin switching follows the registered bypass flag
  sbf_od_bridge u_bridge
  (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_bypass(o_bypass_active),
    .i_host_scl(i_host_scl),
    .i_host_sda(i_host_sda),
    .i_sen_sda(i_sen_sda),
    .i_mst_scl_low(i_mst_scl_low),
    .i_mst_sda_low(i_mst_sda_low),
    .o_host_sda_oe_n(o_host_sda_oe_n),
    .o_sen_scl_oe_n(o_sen_scl_oe_n),
    .o_sen_sda_oe_n(o_sen_sda_oe_n)
  );

  // Operating state and control bits; restart beats a fault, a fault
  // beats host writes, host writes beat firmware progress
  always @*
  begin
    state_nxt = state_r;
    prior_nxt = prior_r;
    proc_ctrl_nxt = proc_ctrl_r;
    byp_ctrl_nxt = byp_ctrl_r;
    if (restart)
    begin
      state_nxt = ST_UNPROG;
      prior_nxt = ST_UNPROG;
      proc_ctrl_nxt = 1'b0;
      byp_ctrl_nxt = 1'b0;
    end
    else if (hw_fault)
    begin
      state_nxt = ST_STANDBY;
      prior_nxt = ST_STANDBY;
      proc_ctrl_nxt = 1'b1;
      byp_ctrl_nxt = 1'b0;
    end
    else
    begin
      if (wr_proc)
        proc_ctrl_nxt = i_reg_wdata[`SBF_BIT_ENABLE];
      if (wr_byp)
        byp_ctrl_nxt = i_reg_wdata[`SBF_BIT_ENABLE];
      case (state_r)
        ST_UNPROG:
        begin
          if (wr_byp && i_reg_wdata[`SBF_BIT_ENABLE])
          begin
            prior_nxt = state_r;
            state_nxt = ST_BYPASS;
          end
          else if (wr_proc && i_reg_wdata[`SBF_BIT_ENABLE])
            state_nxt = ST_STANDBY;
          else if (i_config_done)
            state_nxt = ST_INIT;
        end
        ST_INIT:
        begin
          if (wr_byp && i_reg_wdata[`SBF_BIT_ENABLE])
          begin
            prior_nxt = state_r;
            state_nxt = ST_BYPASS;
          end
          else if (wr_proc && i_reg_wdata[`SBF_BIT_ENABLE])
            state_nxt = ST_STANDBY;
          else if (i_run_request)
            state_nxt = ST_NORMAL;
        end
        ST_NORMAL:
        begin
          if (wr_byp)
            byp_ctrl_nxt = 1'b0;
          if (wr_proc && i_reg_wdata[`SBF_BIT_ENABLE])
            state_nxt = ST_STANDBY;
        end
        ST_STANDBY:
        begin
          if (wr_byp && i_reg_wdata[`SBF_BIT_ENABLE])
          begin
            prior_nxt = state_r;
            state_nxt = ST_BYPASS;
          end
          else if (wr_proc && !i_reg_wdata[`SBF_BIT_ENABLE])
            state_nxt = ST_NORMAL;
        end
        ST_BYPASS:
        begin
          // Processing control writes are kept in the register but never change the state, not even after exit
          if (wr_byp && !i_reg_wdata[`SBF_BIT_ENABLE])
            state_nxt = prior_r;
        end
        default:
        begin
          state_nxt = ST_UNPROG;
        end
      endcase
    end
  end

  // Sticky flags; a new event in the cycle of its clear is kept
  always @*
  begin
    event_nxt = event_r;
    no_ack_nxt = no_ack_r;
    id_err_nxt = id_err_r;
    load_fail_nxt = load_fail_r;
    if (rd_event)
      event_nxt = 2'b00;
    if (restart)
    begin
      event_nxt = 2'b00;
      no_ack_nxt = 3'b000;
      id_err_nxt = 3'b000;
      load_fail_nxt = 1'b0;
    end
    if (restart)
      event_nxt[`SBF_BIT_RESTARTED] = 1'b1;
    if (i_error_event || hw_fault)
      event_nxt[`SBF_BIT_ERROR] = 1'b1;
    if (i_config_fail)
      load_fail_nxt = 1'b1;
    no_ack_nxt = no_ack_nxt | i_no_ack;
    id_err_nxt = id_err_nxt | i_id_mismatch;
  end

  // Sample rates are lost on a fault or restart
  always @*
  begin
    mag_rate_nxt = mag_rate_r;
    acc_rate_nxt = acc_rate_r;
    gyr_rate_nxt = gyr_rate_r;
    if (restart || hw_fault)
    begin
      mag_rate_nxt = `SBF_RST_ZERO;
      acc_rate_nxt = `SBF_RST_ZERO;
      gyr_rate_nxt = `SBF_RST_ZERO;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        `SBF_OFS_MAG_RATE: mag_rate_nxt = i_reg_wdata;
        `SBF_OFS_ACC_RATE: acc_rate_nxt = i_reg_wdata;
        `SBF_OFS_GYR_RATE: gyr_rate_nxt = i_reg_wdata;
        default: mag_rate_nxt = mag_rate_r;
      endcase
    end
  end

  // Read mux; unmapped and write-only offsets read as zero
  always @*
  begin
    case (i_reg_addr)
      `SBF_OFS_EVENT_FLAGS: rdata_nxt = {6'h00, event_r};
      `SBF_OFS_SENSOR_FAULT: rdata_nxt = {1'b0, id_err_r, 1'b0, no_ack_r};
      `SBF_OFS_DEV_COND: rdata_nxt = {4'h0, idle, load_fail_r, 2'b00};
      `SBF_OFS_PROC_STATE: rdata_nxt = {7'h00, state_r == ST_STANDBY};
      `SBF_OFS_FAULT_CODE: rdata_nxt = fault_code;
      `SBF_OFS_PROC_CTRL: rdata_nxt = {7'h00, proc_ctrl_r};
      `SBF_OFS_MAG_RATE: rdata_nxt = mag_rate_r;
      `SBF_OFS_ACC_RATE: rdata_nxt = acc_rate_r;
      `SBF_OFS_GYR_RATE: rdata_nxt = gyr_rate_r;
      `SBF_OFS_BYP_STATE: rdata_nxt = {7'h00, state_r == ST_BYPASS};
      `SBF_OFS_BYP_CTRL: rdata_nxt = {7'h00, byp_ctrl_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // State registers; reset behaves like a restart with the flag raised
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_r <= ST_UNPROG;
      prior_r <= ST_UNPROG;
      proc_ctrl_r <= 1'b0;
      byp_ctrl_r <= 1'b0;
      event_r <= 2'b01;
      no_ack_r <= 3'b000;
      id_err_r <= 3'b000;
      load_fail_r <= 1'b0;
      mag_rate_r <= `SBF_RST_ZERO;
      acc_rate_r <= `SBF_RST_ZERO;
      gyr_rate_r <= `SBF_RST_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      prior_r <= prior_nxt;
      proc_ctrl_r <= proc_ctrl_nxt;
      byp_ctrl_r <= byp_ctrl_nxt;
      event_r <= event_nxt;
      no_ack_r <= no_ack_nxt;
      id_err_r <= id_err_nxt;
      load_fail_r <= load_fail_nxt;
      mag_rate_r <= mag_rate_nxt;
      acc_rate_r <= acc_rate_nxt;
      gyr_rate_r <= gyr_rate_nxt;
    end
  end

  // Output flops; read data are taken in the strobe cycle and shown one cycle later
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
      o_host_sda <= 1'b0;
      o_sen_scl <= 1'b0;
      o_sen_sda <= 1'b0;
      o_fusion_enable <= 1'b0;
      o_sensor_power <= 1'b0;
      o_host_irq <= 1'b0;
      o_bypass_active <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
        o_reg_rdata <= rdata_nxt;
      o_host_sda <= 1'b0;
      o_sen_scl <= 1'b0;
      o_sen_sda <= 1'b0;
      // Sensor settings are never rewritten by this block around bypass
      o_fusion_enable <= (state_nxt == ST_NORMAL);
      o_sensor_power <= (state_nxt == ST_NORMAL);
      o_host_irq <= (event_nxt != 2'b00) && (state_nxt != ST_BYPASS);
      o_bypass_active <= (state_nxt == ST_BYPASS);
    end
  end

endmodule // sbf_bypass_fault_top
`default_nettype wire

// [rtl/sbf_fault_enc.v]
// Fault code encoder: latches the highest-priority fault as a code.
// Assumes fault inputs are one-cycle or level reports from firmware.
`timescale 1ns/10ps
`default_nettype none
`include "sbf_map.vh"
module sbf_fault_enc
(
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_clear,
  input wire i_bad_rate,
  input wire i_math_fault,
  input wire [2:0] i_init_fail,
  input wire [2:0] i_rate_fail,
  output reg [7:0] o_code
);
  // Lowest bit first so one sensor code is reported at a time
  reg [2:0] init_one;
  reg [2:0] rate_one;
  always @*
  begin
    init_one = i_init_fail & (~i_init_fail + 3'h1);
    rate_one = i_rate_fail & (~i_rate_fail + 3'h1);
  end

  // The newest fault overwrites the code; clear needs a restart, and a
  // fault reported in the restart cycle is kept so it is never lost
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_code <= `SBF_CODE_NONE;
    else if (i_bad_rate)
      o_code <= `SBF_CODE_BAD_RATE;
    else if (i_math_fault)
      o_code <= `SBF_CODE_MATH;
    else if (|i_init_fail)
      o_code <= `SBF_CODE_INIT_BASE | {5'h00, init_one};
    else if (|i_rate_fail)
      o_code <= `SBF_CODE_RATE_BASE | {5'h00, rate_one};
    else if (i_clear)
      o_code <= `SBF_CODE_NONE;
  end
endmodule // sbf_fault_enc
`default_nettype wire

// [rtl/sbf_map.vh]
// Register offsets, field positions, reset values and fault codes for
// the bypass and fault status block.
// Assumes an 8-bit register space reached through a decoded serial port.
//
// What this block does
// - In bypass, host serial port is switched straight through to sensor bus.
// - Bypass keeps fusion, host interrupt and device-driven sensor power off.
// - Leaving bypass returns to the state held just before entering it.
// - Sensor registers are untouched on bypass entry; host changes persist.
// - Bypass control at 0xA0 bit 0: 1 enters bypass except from normal operation, 0 leaves it.
// - Bypass status at 0x9E bit 0 reads 1 while in bypass.
// - Processing control at 0x54 bit 0: 1 enters standby, 0 leaves it.
// - Processing status at 0x38 bit 0 reads 1 while in standby.
// - Hardware fault forces standby, sensors off and a host interrupt.
// - Event flags 0x35: bit 0 after processor reset, bit 1 on error.
// - Device condition 0x37 bit 2 flags a failed configuration load.
// - Device condition bit 3 shows idle in initialized or unprogrammed state.
// - Sensor faults 0x36: no-ack in bits 0-2, identity mismatch in 4-6.
// - Fault code 0x50: 0x00 none, 0x80 bad rate, 0x30 maths fault.
// - Fault code 0x21, 0x22, 0x24 for sensor initialization failure.
// - Fault code 0x11, 0x12, 0x14 for a sensor that stopped giving data.
// - Reading event flags returns them and then clears the whole register.
// - Writing 0x01 to 0x9B restarts the device into the unprogrammed state.
`ifndef SBF_MAP_VH
`define SBF_MAP_VH

`define SBF_OFS_EVENT_FLAGS 8'h35
`define SBF_OFS_SENSOR_FAULT 8'h36
`define SBF_OFS_DEV_COND 8'h37
`define SBF_OFS_PROC_STATE 8'h38
`define SBF_OFS_FAULT_CODE 8'h50
`define SBF_OFS_PROC_CTRL 8'h54
`define SBF_OFS_MAG_RATE 8'h55
`define SBF_OFS_ACC_RATE 8'h56
`define SBF_OFS_GYR_RATE 8'h57
`define SBF_OFS_RESTART 8'h9b
`define SBF_OFS_BYP_STATE 8'h9e
`define SBF_OFS_BYP_CTRL 8'ha0

`define SBF_BIT_RESTARTED 0
`define SBF_BIT_ERROR 1
`define SBF_BIT_LOAD_FAIL 2
`define SBF_BIT_IDLE 3
`define SBF_BIT_ENABLE 0

`define SBF_RESTART_CMD 8'h01
`define SBF_RST_EVENT 8'h01
`define SBF_RST_ZERO 8'h00

`define SBF_CODE_NONE 8'h00
`define SBF_CODE_BAD_RATE 8'h80
`define SBF_CODE_MATH 8'h30
`define SBF_CODE_INIT_BASE 8'h20
`define SBF_CODE_RATE_BASE 8'h10

`endif

// [rtl/sbf_od_bridge.v]
// Open-drain switch between host serial port, sensor bus and the
// internal sensor master. Assumes all pin levels are synchronous.
`timescale 1ns/10ps
`default_nettype none
module sbf_od_bridge
(
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_bypass,
  input wire i_host_scl,
  input wire i_host_sda,
  input wire i_sen_sda,
  input wire i_mst_scl_low,
  input wire i_mst_sda_low,
  output reg o_host_sda_oe_n,
  output reg o_sen_scl_oe_n,
  output reg o_sen_sda_oe_n
);
  // A low seen on one side is copied to the other; a side we are already
  // pulling low is not echoed back, which would latch the line low forever
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_host_sda_oe_n <= 1'b1;
      o_sen_scl_oe_n <= 1'b1;
      o_sen_sda_oe_n <= 1'b1;
    end
    else if (i_bypass)
    begin
      // Internal master is cut off, so sensor settings change only by the host
      o_sen_scl_oe_n <= i_host_scl;
      o_sen_sda_oe_n <= i_host_sda | ~o_host_sda_oe_n;
      o_host_sda_oe_n <= i_sen_sda | ~o_sen_sda_oe_n;
    end
    else
    begin
      o_sen_scl_oe_n <= ~i_mst_scl_low;
      o_sen_sda_oe_n <= ~i_mst_sda_low;
      o_host_sda_oe_n <= 1'b1;
    end
  end
endmodule // sbf_od_bridge
`default_nettype wire
